/* File: hdl/lbc_consts.svh */
// Constants for the local bus control pin block
`ifndef LBC_CONSTS_SVH
`define LBC_CONSTS_SVH

// Upper select window after reset: memory space, top 1 KiB of the 1 MiB map
`define LBC_UCS_RST_BASE 20'hffc00
`define LBC_UCS_RST_TOP  20'hfffff
`define LBC_UCS_RST_IO   1'b0
`define LBC_UCS_RST_EN   1'b1

// Chip-select table slots as seen on the programming port
`define LBC_CS_UPPER     4'h0
`define LBC_CS_LOWER     4'h1
`define LBC_CS_GEN0      4'h2

// Interrupt type raised by a pending numerics error
`define LBC_NUM_ERR_TYPE 8'h10

`endif

/* File: hdl/lbc_pkg.sv */
// Types shared by the local bus control pin block
package lbc_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_DATA,
		ST_END,
		ST_FLOAT,
		ST_HOLD
	} lbc_state_e;

	typedef logic [19:0] lbc_addr_t;
endpackage

/* File: hdl/lbc_range_match.sv */
// Address window compare for one chip-select slot
`timescale 1ns/1ps
`default_nettype none
module lbc_range_match
	import lbc_pkg::*;
(
	input  wire lbc_addr_t addr,
	input  wire logic      is_io,
	input  wire lbc_addr_t base,
	input  wire lbc_addr_t top,
	input  wire logic      space_io,
	input  wire logic      enable,
	output logic           hit
);
	// Inclusive on both ends so a window may cover a single location
	always_comb begin
		hit = enable && (is_io == space_io) && (addr >= base) && (addr <= top);
	end
endmodule // lbc_range_match
`default_nettype wire

/* File: hdl/lbc_bus_ctrl.sv */
// Local bus control pins: strobes, transceiver, hold, selects, coprocessor
// Notes on behaviour
// - read strobe low to fetch data; floats in hold and reset, high when idle.
// - write strobe low to store data; floats in hold and reset, high when idle.
// - a cycle ends only on READY, unless its select says ignore READY.
// - READY is synchronised in rising mode, used directly in falling mode.
// - transceiver enable low only in data phase; floats hold/reset, high idle.
// - transceiver direction steers buffers; floats hold/reset, else keeps value.
// - while lock is active no hold is granted.
// - hold is granted only at an unlocked instruction boundary.
// - hold grant rises only after the bus floated; low in reset and idle.
// - upper select matches its window; after reset memory 0FFC00H to 0FFFFFH.
// - lower select matches its window; inactive after reset until programmed.
// - eight general selects, or port outputs when not enabled; enabled selects high in hold, port outputs keep their value.
// - coprocessor select low on coprocessor access; high otherwise.
// - error sampled active at numerics start raises interrupt type 16.
// - coprocessor request flags a pending coprocessor memory transfer.
`timescale 1ns/1ps
`default_nettype none
`include "lbc_consts.svh"
module lbc_bus_ctrl
	import lbc_pkg::*;
#(
	parameter int NUM_GEN = 8
) (
	input  wire logic               CLK,
	input  wire logic               ARST_N,
	input  wire logic               CYC_REQ,
	input  wire logic               CYC_WRITE,
	input  wire logic               CYC_IO,
	input  wire lbc_addr_t          CYC_ADDR,
	input  wire logic               CYC_COPROC,
	input  wire logic               CYC_LOCK,
	input  wire logic               INSN_BOUNDARY,
	input  wire logic               HOLD,
	input  wire logic               READY,
	input  wire logic               READY_ON_RISE,
	input  wire logic               IDLE_MODE,
	input  wire logic               POWERDOWN_MODE,
	input  wire logic               NUM_ERROR_N,
	input  wire logic               COPROC_XFER_REQ,
	input  wire logic               CS_WR,
	input  wire logic [3:0]         CS_SEL,
	input  wire lbc_addr_t          CS_BASE,
	input  wire lbc_addr_t          CS_TOP,
	input  wire logic               CS_IO,
	input  wire logic               CS_EN,
	input  wire logic               CS_NO_READY,
	input  wire logic [NUM_GEN-1:0] GP_PORT,
	output logic                    CYC_ACK,
	output logic                    CYC_DONE,
	output logic                    RD_N,
	output logic                    RD_OE,
	output logic                    WR_N,
	output logic                    WR_OE,
	output logic                    TRANSCEIVER_ENABLE_N,
	output logic                    TRANSCEIVER_ENABLE_OE,
	output logic                    TRANSCEIVER_DIRECTION,
	output logic                    TRANSCEIVER_DIRECTION_OE,
	output logic                    LOCK_N,
	output logic                    LOCK_OE,
	output logic                    HOLD_GRANT,
	output logic                    UPPER_SELECT_N,
	output logic                    LOWER_SELECT_N,
	output logic [NUM_GEN-1:0]      GENERAL_SELECT_N,
	output logic                    COPROCESSOR_SELECT_N,
	output logic                    NUM_ERR_INT,
	output logic [7:0]              NUM_ERR_TYPE,
	output logic                    COPROCESSOR_TRANSFER_PEND
);
	localparam int COPROCESSOR_SELECT = NUM_GEN + 2;

	// Chip-select table: slot 0 upper, slot 1 lower, then the general selects
	lbc_addr_t        cfg_base_q [COPROCESSOR_SELECT];
	lbc_addr_t        cfg_top_q  [COPROCESSOR_SELECT];
	logic [COPROCESSOR_SELECT-1:0]   cfg_io_q, cfg_en_q, cfg_nordy_q;
	logic [COPROCESSOR_SELECT-1:0]   hit;

	genvar i;
	generate
		for (i = 0; i < COPROCESSOR_SELECT; i++) begin : g_cs
			localparam lbc_addr_t BASE_RST = (i == 0) ? `LBC_UCS_RST_BASE : 20'h00000;
			localparam lbc_addr_t TOP_RST  = (i == 0) ? `LBC_UCS_RST_TOP : 20'h00000;
			localparam logic      EN_RST   = (i == 0) ? `LBC_UCS_RST_EN : 1'b0;
			lbc_addr_t base_d, top_d;
			logic      io_d, en_d, nordy_d, wr_me;
			always_comb begin
				wr_me   = CS_WR && (CS_SEL == 4'(i));
				base_d  = wr_me ? CS_BASE : cfg_base_q[i];
				top_d   = wr_me ? CS_TOP : cfg_top_q[i];
				io_d    = wr_me ? CS_IO : cfg_io_q[i];
				en_d    = wr_me ? CS_EN : cfg_en_q[i];
				nordy_d = wr_me ? CS_NO_READY : cfg_nordy_q[i];
			end
			always_ff @(posedge CLK or negedge ARST_N) begin
				if (!ARST_N) begin
					cfg_base_q[i]  <= BASE_RST;
					cfg_top_q[i]   <= TOP_RST;
					cfg_io_q[i]    <= `LBC_UCS_RST_IO;
					cfg_en_q[i]    <= EN_RST;
					cfg_nordy_q[i] <= 1'b0;
				end else begin
					cfg_base_q[i]  <= base_d;
					cfg_top_q[i]   <= top_d;
					cfg_io_q[i]    <= io_d;
					cfg_en_q[i]    <= en_d;
					cfg_nordy_q[i] <= nordy_d;
				end
			end
			lbc_range_match u_match (
				.addr     (CYC_ADDR),
				.is_io    (CYC_IO),
				.base     (cfg_base_q[i]),
				.top      (cfg_top_q[i]),
				.space_io (cfg_io_q[i]),
				.enable   (cfg_en_q[i]),
				.hit      (hit[i])
			);
		end
	endgenerate

	// Input synchronisers; the first stage feeds only the second
	logic rdy_s1_q, rdy_s2_q, req_s1_q, req_s2_q, ready_ok;
	logic [1:0] dcnt_q, dcnt_d;
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rdy_s1_q <= 1'b0;
			rdy_s2_q <= 1'b0;
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
		end else begin
			rdy_s1_q <= READY;
			rdy_s2_q <= rdy_s1_q;
			req_s1_q <= COPROC_XFER_REQ;
			req_s2_q <= req_s1_q;
		end
	end
	// Falling-edge mode relies on the far side meeting setup, so no extra delay
	// The two-flop pipe still holds READY from before the strobe for two edges,
	// so rising mode ignores it until the data phase is two edges old
	assign ready_ok = READY_ON_RISE ? (rdy_s2_q && dcnt_q == 2'h2) : READY;

	// Sequencer and cycle attributes
	lbc_state_e     st_q, st_d;
	logic           wr_q, wr_d, cp_q, cp_d, nordy_q, nordy_d, lock_q, lock_d;
	logic           dtr_q, dtr_d;
	logic [COPROCESSOR_SELECT-1:0] hit_q, hit_d;
	logic           low_power, take, grant;

	always_comb begin
		low_power = IDLE_MODE || POWERDOWN_MODE;
		grant = HOLD && INSN_BOUNDARY && !lock_q && !CYC_LOCK && !low_power;
		take  = CYC_REQ && !low_power && !grant;
		st_d    = st_q;
		wr_d    = wr_q;
		cp_d    = cp_q;
		nordy_d = nordy_q;
		lock_d  = lock_q;
		dtr_d   = dtr_q;
		hit_d   = hit_q;
		dcnt_d  = (st_q != ST_DATA) ? 2'h0 : (dcnt_q == 2'h2) ? dcnt_q : dcnt_q + 2'h1;
		case (st_q)
			ST_IDLE: begin
				lock_d = CYC_LOCK;
				if (grant) begin
					st_d = ST_FLOAT;
				end else if (take) begin
					st_d    = ST_ADDR;
					wr_d    = CYC_WRITE;
					cp_d    = CYC_COPROC;
					dtr_d   = CYC_WRITE;
					hit_d   = hit;
					nordy_d = |(hit & cfg_nordy_q);
				end
			end
			ST_ADDR: st_d = ST_DATA;
			ST_DATA: begin
				if (ready_ok || nordy_q) begin
					st_d = ST_END;
				end
			end
			ST_END: begin
				st_d  = ST_IDLE;
				hit_d = '0;
				cp_d  = 1'b0;
			end
			ST_FLOAT: st_d = ST_HOLD;
			ST_HOLD: begin
				if (!HOLD) begin
					st_d = ST_IDLE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			st_q    <= ST_IDLE;
			wr_q    <= 1'b0;
			cp_q    <= 1'b0;
			nordy_q <= 1'b0;
			lock_q  <= 1'b0;
			dtr_q   <= 1'b0;
			hit_q   <= '0;
			dcnt_q  <= 2'h0;
		end else begin
			dcnt_q  <= dcnt_d;
			st_q    <= st_d;
			wr_q    <= wr_d;
			cp_q    <= cp_d;
			nordy_q <= nordy_d;
			lock_q  <= lock_d;
			dtr_q   <= dtr_d;
			hit_q   <= hit_d;
		end
	end

	// Pin values, computed from the next state so the pins change with it
	logic               float_d, in_cyc_d;
	logic               ack_d, done_d, rd_d, wr_o_d, den_d, lockn_d, hold_grant_d;
	logic               ucs_d, lcs_d, ncs_d, err_d, pend_d;
	logic [NUM_GEN-1:0] gcs_d, port_q, port_d;
	always_comb begin
		float_d  = (st_d == ST_FLOAT) || (st_d == ST_HOLD);
		in_cyc_d = (st_d == ST_ADDR) || (st_d == ST_DATA) || (st_d == ST_END);
		ack_d    = (st_q == ST_IDLE) && (st_d == ST_ADDR);
		done_d   = (st_d == ST_END);
		rd_d     = !((st_d == ST_DATA) && !wr_d);
		wr_o_d   = !((st_d == ST_DATA) && wr_d);
		den_d    = !(st_d == ST_DATA);
		lockn_d  = !lock_d;
		hold_grant_d   = (st_d == ST_HOLD);
		ucs_d    = !(in_cyc_d && hit_d[0]);
		lcs_d    = !(in_cyc_d && hit_d[1]);
		ncs_d    = !(in_cyc_d && cp_d);
		err_d    = ack_d && CYC_COPROC && !NUM_ERROR_N;
		pend_d   = req_s2_q;
		// Port values freeze in hold and low power, like a latched pin
		port_d   = (float_d || low_power) ? port_q : GP_PORT;
		for (int g = 0; g < NUM_GEN; g++) begin
			gcs_d[g] = cfg_en_q[g+2] ? !(in_cyc_d && hit_d[g+2]) : port_d[g];
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			CYC_ACK                   <= 1'b0;
			CYC_DONE                  <= 1'b0;
			RD_N                      <= 1'b1;
			RD_OE                     <= 1'b0;
			WR_N                      <= 1'b1;
			WR_OE                     <= 1'b0;
			TRANSCEIVER_ENABLE_N      <= 1'b1;
			TRANSCEIVER_ENABLE_OE     <= 1'b0;
			TRANSCEIVER_DIRECTION     <= 1'b0;
			TRANSCEIVER_DIRECTION_OE  <= 1'b0;
			LOCK_N                    <= 1'b1;
			LOCK_OE                   <= 1'b0;
			HOLD_GRANT                <= 1'b0;
			UPPER_SELECT_N            <= 1'b1;
			LOWER_SELECT_N            <= 1'b1;
			GENERAL_SELECT_N          <= '1;
			COPROCESSOR_SELECT_N      <= 1'b1;
			NUM_ERR_INT               <= 1'b0;
			NUM_ERR_TYPE              <= `LBC_NUM_ERR_TYPE;
			COPROCESSOR_TRANSFER_PEND <= 1'b0;
			port_q                    <= '1;
		end else begin
			CYC_ACK                   <= ack_d;
			CYC_DONE                  <= done_d;
			RD_N                      <= rd_d;
			RD_OE                     <= !float_d;
			WR_N                      <= wr_o_d;
			WR_OE                     <= !float_d;
			TRANSCEIVER_ENABLE_N      <= den_d;
			TRANSCEIVER_ENABLE_OE     <= !float_d;
			TRANSCEIVER_DIRECTION     <= dtr_d;
			TRANSCEIVER_DIRECTION_OE  <= !float_d;
			LOCK_N                    <= lockn_d;
			LOCK_OE                   <= !float_d;
			HOLD_GRANT                <= hold_grant_d;
			UPPER_SELECT_N            <= ucs_d;
			LOWER_SELECT_N            <= lcs_d;
			GENERAL_SELECT_N          <= gcs_d;
			COPROCESSOR_SELECT_N      <= ncs_d;
			NUM_ERR_INT               <= err_d;
			NUM_ERR_TYPE              <= `LBC_NUM_ERR_TYPE;
			COPROCESSOR_TRANSFER_PEND <= pend_d;
			port_q                    <= port_d;
		end
	end

	a_rd_strobe:
	assert property (@(posedge CLK) disable iff (!ARST_N)
		(st_q == ST_DATA && !wr_q) <-> (!RD_N && RD_OE))
		else $error("read strobe does not match data phase of a read");
	a_wr_strobe:
	assert property (@(posedge CLK) disable iff (!ARST_N)
		(st_q == ST_DATA && wr_q) <-> (!WR_N && WR_OE))
		else $error("write strobe does not match data phase of a write");
	a_wait_ready:
	assert property (@(posedge CLK) disable iff (!ARST_N)
		(st_q == ST_DATA && !ready_ok && !nordy_q) |=> (st_q == ST_DATA && !CYC_DONE))
		else $error("cycle ended without READY");
	a_ready_sync:
	assert property (@(posedge CLK) disable iff (!ARST_N)
		$rose(rdy_s2_q) |-> $past(READY, 2))
		else $error("synchronised READY rose without input");
	a_den_data:
	assert property (@(posedge CLK) disable iff (!ARST_N)
		!TRANSCEIVER_ENABLE_N |-> (st_q == ST_DATA && TRANSCEIVER_ENABLE_OE))
		else $error("transceiver enable outside data phase");
	a_dir_float:
	assert property (@(posedge CLK) disable iff (!ARST_N)
		(st_q == ST_HOLD) |-> (!TRANSCEIVER_DIRECTION_OE && $stable(TRANSCEIVER_DIRECTION)))
		else $error("direction driven or changed in hold");
	a_lock_no_grant:
	assert property (@(posedge CLK) disable iff (!ARST_N)
		$rose(HOLD_GRANT) |-> $past(!lock_q, 2))
		else $error("hold granted during locked sequence");
	a_hold_boundary:
	assert property (@(posedge CLK) disable iff (!ARST_N)
		(st_q == ST_FLOAT) |-> $past(INSN_BOUNDARY && !CYC_LOCK && HOLD))
		else $error("bus released away from an unlocked boundary");
	a_grant_after_float:
	assert property (@(posedge CLK) disable iff (!ARST_N)
		$rose(HOLD_GRANT) |-> (!RD_OE && !WR_OE && !TRANSCEIVER_ENABLE_OE && $past(!RD_OE)))
		else $error("hold grant before outputs floated");
	a_upper_window:
	assert property (@(posedge CLK) disable iff (!ARST_N)
		!UPPER_SELECT_N |-> (hit_q[0] && st_q inside {ST_ADDR, ST_DATA, ST_END}))
		else $error("upper select outside a matching cycle");
	a_lower_window:
	assert property (@(posedge CLK) disable iff (!ARST_N)
		!LOWER_SELECT_N |-> (hit_q[1] && $past(cfg_en_q[1], 1)))
		else $error("lower select active while unprogrammed");
	a_gen_hold_high:
	assert property (@(posedge CLK) disable iff (!ARST_N)
		(st_q == ST_HOLD) |-> ((GENERAL_SELECT_N | ~cfg_en_q[COPROCESSOR_SELECT-1:2]) == '1))
		else $error("general select active in hold");
	a_coproc_select:
	assert property (@(posedge CLK) disable iff (!ARST_N)
		!COPROCESSOR_SELECT_N |-> (cp_q && HOLD_GRANT == 1'b0))
		else $error("coprocessor select without coprocessor cycle");
	a_num_error:
	assert property (@(posedge CLK) disable iff (!ARST_N)
		NUM_ERR_INT |-> (NUM_ERR_TYPE == `LBC_NUM_ERR_TYPE && $past(!NUM_ERROR_N && CYC_COPROC)))
		else $error("numerics error interrupt without sampled error");
	a_xfer_pend:
	assert property (@(posedge CLK) disable iff (!ARST_N)
		$rose(COPROCESSOR_TRANSFER_PEND) |-> $past(COPROC_XFER_REQ, 3))
		else $error("transfer pending without coprocessor request");
endmodule // lbc_bus_ctrl
`default_nettype wire

/* File: tb/lbc_far_model.sv */
// Far-side memory or I/O device that answers a strobe with READY
`timescale 1ns/1ps
`default_nettype none
module lbc_far_model (
	input  wire logic       clk,
	input  wire logic       rd_n,
	input  wire logic       rd_oe,
	input  wire logic       wr_n,
	input  wire logic       wr_oe,
	input  wire logic [3:0] waits,
	output logic            ready
);
	logic [3:0] cnt_q = 4'h0;
	logic       tog_q = 1'b0;
	logic       act;

	assign act = (rd_oe && !rd_n) || (wr_oe && !wr_n);

	// Changes only just after the rising edge, so READY is synchronous to it
	always_ff @(posedge clk) begin
		cnt_q <= act ? ((cnt_q == 4'hf) ? cnt_q : cnt_q + 4'h1) : 4'h0;
		tog_q <= !tog_q;
	end

	// Outside a strobe READY toggles, so a design that reads it there shows up.
	// Waits of 4'hf never answer: only used against windows that ignore READY.
	assign ready = act ? (waits != 4'hf && cnt_q >= waits) : tog_q;
endmodule // lbc_far_model
`default_nettype wire

/* File: tb/lbc_bus_ctrl_bench.sv */
// Self-checking bench for the local bus control pin block
`timescale 1ns/1ps
`default_nettype none
`include "lbc_consts.svh"
module lbc_bus_ctrl_bench;
	import lbc_pkg::*;
	logic      clk = 1'b0, arst_n = 1'b0, req = 1'b0, wr = 1'b0, io = 1'b0, cop = 1'b0;
	logic      lck = 1'b0, bnd = 1'b1, hold = 1'b0, rise = 1'b0, idle = 1'b0, pdn = 1'b0;
	logic      err_n = 1'b1, xreq = 1'b0, cs_wr = 1'b0, cs_io = 1'b0, cs_en = 1'b0;
	logic      cs_nr = 1'b0, lo_on = 1'b0, g0_on = 1'b0, ready;
	lbc_addr_t addr = '0, cs_base = '0, cs_top = '0;
	logic [3:0] cs_sel = 4'h0, waits = 4'h0;
	logic [7:0] gp = 8'h5a, gen_n, etype;
	logic      ack, done, rd_n, rd_oe, wr_n, wr_oe, ten_n, ten_oe, tdir, tdir_oe;
	logic      lock_n, lock_oe, grant, up_n, lo_n, cop_n, eint, pend;
	int        fail_count = 0, n_tests = 0, cycles = 0, seed_v;

	// Nothing outside drives the lock line, so it is never pulled low in reset
	lbc_bus_ctrl #(.NUM_GEN(8)) dut (
		.CLK(clk), .ARST_N(arst_n), .CYC_REQ(req), .CYC_WRITE(wr), .CYC_IO(io),
		.CYC_ADDR(addr), .CYC_COPROC(cop), .CYC_LOCK(lck), .INSN_BOUNDARY(bnd),
		.HOLD(hold), .READY(ready), .READY_ON_RISE(rise), .IDLE_MODE(idle),
		.POWERDOWN_MODE(pdn), .NUM_ERROR_N(err_n), .COPROC_XFER_REQ(xreq),
		.CS_WR(cs_wr), .CS_SEL(cs_sel), .CS_BASE(cs_base), .CS_TOP(cs_top),
		.CS_IO(cs_io), .CS_EN(cs_en), .CS_NO_READY(cs_nr), .GP_PORT(gp),
		.CYC_ACK(ack), .CYC_DONE(done), .RD_N(rd_n), .RD_OE(rd_oe), .WR_N(wr_n),
		.WR_OE(wr_oe), .TRANSCEIVER_ENABLE_N(ten_n), .TRANSCEIVER_ENABLE_OE(ten_oe),
		.TRANSCEIVER_DIRECTION(tdir), .TRANSCEIVER_DIRECTION_OE(tdir_oe),
		.LOCK_N(lock_n), .LOCK_OE(lock_oe), .HOLD_GRANT(grant), .UPPER_SELECT_N(up_n),
		.LOWER_SELECT_N(lo_n), .GENERAL_SELECT_N(gen_n), .COPROCESSOR_SELECT_N(cop_n),
		.NUM_ERR_INT(eint), .NUM_ERR_TYPE(etype), .COPROCESSOR_TRANSFER_PEND(pend)
	);

	lbc_far_model far (
		.clk(clk), .rd_n(rd_n), .rd_oe(rd_oe), .wr_n(wr_n), .wr_oe(wr_oe),
		.waits(waits), .ready(ready)
	);

	initial begin
		forever #5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("Checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic step;
		@(posedge clk);
		#1;
	endtask

	function automatic logic exp_up(input lbc_addr_t a, input logic i);
		return !i && a >= `LBC_UCS_RST_BASE && a <= `LBC_UCS_RST_TOP;
	endfunction

	function automatic logic [2:0] exp_sel(input lbc_addr_t a, input logic i, input logic c);
		return ~{exp_up(a, i), lo_on && !i && a <= 20'h003ff, c};
	endfunction

	function automatic logic exp_g0(input lbc_addr_t a, input logic i);
		return g0_on ? !(!i && a >= 20'h40000 && a <= 20'h4ffff) : gp[0];
	endfunction

	task automatic bus_cycle(input lbc_addr_t a, input logic w, input logic i,
			input logic c, input logic [3:0] wt);
		int k;
		int n;
		n = 0;
		{addr, wr, io, cop, waits, req} = {a, w, i, c, wt, 1'b1};
		k = 0;
		while (ack !== 1'b1 && k < 20) begin
			step();
			k++;
		end
		chk("num_int", eint, c & !err_n);
		req = 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 40) begin
			if (rd_n === 1'b0 || wr_n === 1'b0) begin
				n++;
				chk("strobes", {rd_n, wr_n, rd_oe, wr_oe}, w ? 4'b1011 : 4'b0111);
				chk("xcvr", {ten_n, ten_oe, tdir, tdir_oe}, {2'b01, w, 1'b1});
				chk("selects", {up_n, lo_n, cop_n}, exp_sel(a, i, c));
				chk("general", gen_n, {gp[7:1], exp_g0(a, i)});
			end
			step();
			k++;
		end
		chk("done", {done, n > 0}, 2'b11);
		chk("wait_len", (g0_on && !i && a[19:16] == 4'h4) ? n == 1 : n > wt, 1);
	endtask

	task automatic rnd_cycle;
		lbc_addr_t a;
		int s;
		s = $urandom % 3;
		a = (s == 0) ? {10'h3ff, 10'($urandom)} : (s == 1) ? 20'($urandom % 2048)
			: {4'h4, 16'($urandom)};
		{rise, gp, err_n} = {1'($urandom), 8'($urandom), 1'($urandom)};
		if ($urandom % 5 == 0) bus_cycle(20'h000f8, 1'($urandom), 1'b1, 1'b1, 4'($urandom % 4));
		else bus_cycle(a, 1'($urandom), 1'($urandom), 1'b0, 4'($urandom % 4));
	endtask

	task automatic cs_prog(input logic [3:0] s, input lbc_addr_t b, input lbc_addr_t t,
			input logic nr);
		{cs_wr, cs_sel, cs_base, cs_top, cs_io, cs_en, cs_nr} = {1'b1, s, b, t, 2'b01, nr};
		step();
		cs_wr = 1'b0;
	endtask

	initial begin
		seed_v = $urandom(32'hb598);
		repeat (10) step();
		chk("rst_oe", {rd_oe, wr_oe, ten_oe, tdir_oe, lock_oe, grant}, 0);
		chk("rst_sel", {up_n, lo_n, gen_n, cop_n}, 11'h7ff);
		chk("int_type", etype, `LBC_NUM_ERR_TYPE);
		repeat (10) step();
		arst_n = 1'b1;
		step();
		chk("driven", {rd_n, wr_n, ten_n, rd_oe, wr_oe, ten_oe}, 6'h3f);
		chk("port", gen_n, gp);
		repeat (20) rnd_cycle();
		lo_on = 1'b1;
		g0_on = 1'b1;
		cs_prog(`LBC_CS_LOWER, 20'h00000, 20'h003ff, 1'b0);
		cs_prog(`LBC_CS_GEN0, 20'h40000, 20'h4ffff, 1'b1);
		repeat (30) rnd_cycle();
		// Far side never answers; the window's ignore-READY setting must end it
		bus_cycle(20'h40010, 1'b0, 1'b0, 1'b0, 4'hf);
		err_n = 1'b0;
		bus_cycle(20'h000f8, 1'b0, 1'b1, 1'b1, 4'h0);
		err_n = 1'b1;
		for (int m = 1; m < 3; m++) begin
			{idle, pdn, req} = {2'(m), 1'b1};
			repeat (4) step();
			chk("low_power", {ack, rd_n, wr_n, ten_n, rd_oe, ten_oe}, 6'h1f);
			{idle, pdn, req} = 3'b000;
			step();
		end
		lck = 1'b1;
		bus_cycle(20'h00020, 1'b1, 1'b0, 1'b0, 4'h1);
		hold = 1'b1;
		repeat (4) step();
		chk("locked", {lock_n, lock_oe, grant}, 3'b010);
		{lck, bnd} = 2'b00;
		repeat (4) step();
		chk("no_boundary", grant, 0);
		bnd = 1'b1;
		step();
		chk("float", {rd_oe, wr_oe, ten_oe, tdir_oe, lock_oe, grant}, 0);
		step();
		chk("grant", {grant, up_n, cop_n, gen_n[0], rd_oe}, 5'b11110);
		hold = 1'b0;
		step();
		chk("release", {grant, rd_oe, rd_n}, 3'b011);
		xreq = 1'b1;
		repeat (2) step();
		chk("pend_early", pend, 0);
		step();
		chk("pend", pend, 1);
		xreq = 1'b0;
		report_and_stop();
	end
endmodule // lbc_bus_ctrl_bench
`default_nettype wire
